// ==== design/xfp_pkg.sv ====
// Package for the receive fabric port and core clocking block.
// Assumes one clock domain; clock sources are modelled as tick strobes.
package xfp_pkg;

  // ==========================================================
  // Register map (AXI4-Lite byte addresses)
  // ==========================================================
  localparam logic [7:0] ADDR_CTRL     = 8'h00;  // Rate divider selects
  localparam logic [7:0] ADDR_STATUS   = 8'h04;  // Reconfiguration state
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;  // Sticky events, read only
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0C;  // Write one to clear
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;  // Interrupt enables

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [3:0]  IRQ_EN_RST = 4'h0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Receive bus field positions, per 16-bit half
  // ==========================================================
  localparam int HALF_W    = 16;  // Upper word starts here
  localparam int F_DATA    = 0;   // 10-bit data
  localparam int F_SYNC    = 10;  // Alignment lock
  localparam int F_PATTERN = 12;  // Alignment pattern match
  localparam int F_DELETE  = 13;  // Rate-match deletion / pipe status lsb
  localparam int F_INSERT  = 14;  // Rate-match insertion / pipe status msb
  localparam int F_DISP    = 15;  // Running disparity

  // Status register fields
  localparam int S_BUSY  = 0;
  localparam int S_AVAL  = 1;
  localparam int S_ADDR  = 8;   // 6 bits
  localparam int S_MODE  = 16;  // 3 bits
  localparam int S_MASK  = 24;  // Updated channel mask

  // Interrupt bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_DELETE = 1;
  localparam int IRQ_INSERT = 2;
  localparam int IRQ_UNLOCK = 3;

  // ==========================================================
  // Types
  // ==========================================================
  // One received word with its status
  typedef struct packed {
    logic [9:0] data;
    logic       sync;
    logic       pattern;
    logic       rmDelete;
    logic       rmInsert;
    logic [1:0] pipeStatus;
    logic       runDisp;
  } xfp_word_t;

  // Transmit FIFO write clock choice
  typedef enum logic {TX_SHARED, TX_OWN} xfp_txsrc_t;

  // Receive FIFO read clock choice
  typedef enum logic [1:0] {RX_SHARED_TX, RX_OWN_TX, RX_OWN_RX} xfp_rxsrc_t;

endpackage : xfp_pkg

// ==== design/xfp_fabric_port.sv ====
// Receive fabric port, core clock selection and channel reconfiguration
// status for a multi-channel transceiver block.
// Assumes mclk is the only clock; every parallel clock arrives as a
// one-cycle tick on mclk, and inputs are synchronous to mclk.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps

module xfp_fabric_port #(
  parameter int                 NCH       = 4,              // Channels
  parameter int                 CHW       = 2,              // Channel index width
  parameter logic [5:0]         ADDR_LAST = 6'h0F,          // Last reconfig address
  parameter xfp_pkg::xfp_txsrc_t TX_SRC   = xfp_pkg::TX_SHARED,
  parameter xfp_pkg::xfp_rxsrc_t RX_SRC   = xfp_pkg::RX_OWN_RX,
  parameter logic               TX_FABRIC = 1'b0,           // Fabric tx clock in use
  parameter logic               RX_FABRIC = 1'b0            // Fabric rx clock in use
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // AXI4-Lite slave
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Receive words from the channels
  input  wire xfp_pkg::xfp_word_t [NCH-1:0] rxLower,
  input  wire xfp_pkg::xfp_word_t [NCH-1:0] rxUpper,
  input  wire logic [NCH-1:0]            rxWordValid,
  input  wire logic [NCH-1:0]            pipeMode,
  // Parallel clock ticks
  input  wire logic [NCH-1:0]            txClkTick,
  input  wire logic [NCH-1:0]            rxClkTick,
  input  wire logic [NCH-1:0]            fabricTxTick,
  input  wire logic [NCH-1:0]            fabricRxTick,
  // Fabric receive bus and FIFO clock strobes
  output logic [NCH-1:0][31:0]           rxBus,
  output logic [NCH-1:0]                 rxBusValid,
  output logic [NCH-1:0]                 txWriteTick,
  output logic [NCH-1:0]                 rxReadTick,
  // Reconfiguration controls
  input  wire logic                      reconfigStart,
  input  wire logic [CHW-1:0]            logicalChannel,
  input  wire logic                      addrRestart,
  input  wire logic                      reconfigReset,
  input  wire logic [2:0]                reconfigModeSel,
  input  wire logic                      writeAll,
  // Reconfiguration status
  output logic                           addrValid,
  output logic [5:0]                     addrOut,
  output logic                           channelDone,
  output logic                           busy,
  // Interrupt
  output logic                           irq
);

  // ==========================================================
  // Declarations
  // ==========================================================
  typedef enum {ST_IDLE, ST_RUN, ST_DONE} xfp_state_t;

  xfp_state_t      state_ff;        // Reconfiguration sequencer
  logic [2:0]      mode_ff;         // Latched mode select
  logic [NCH-1:0]  chanMask_ff;     // Channels being updated
  logic [NCH-1:0]  rxDiv2_ff;       // Divide-by-2 selects
  logic [NCH-1:0]  divPhase_ff;     // Divider phase per channel
  logic [NCH-1:0]  rxEffTick;       // Recovered tick after divider
  logic [NCH-1:0]  nxt_readTick;    // Selected receive read strobe
  logic [NCH-1:0]  nxt_writeTick;   // Selected transmit write strobe
  logic [NCH-1:0]  syncPrev_ff;     // Lock seen last word
  logic [3:0]      irqStat_ff;      // Sticky events
  logic [3:0]      irqEn_ff;        // Event enables
  logic [3:0]      evt;             // Events this cycle
  logic [7:0]      awAddr_ff;       // Held write address
  logic            awHeld_ff;       // Write address taken
  logic [31:0]     wData_ff;        // Held write data
  logic [3:0]      wStrb_ff;        // Held byte enables
  logic            wHeld_ff;        // Write data taken
  logic            doWrite;         // Both halves present
  logic [3:0]      clrMask;         // Write-one clear pattern
  logic [31:0]     nxt_rdata;       // Read mux
  logic            rdHit;           // Read address mapped

  // Pack one word into its 16-bit half of the bus
  function automatic logic [15:0] packHalf(input xfp_pkg::xfp_word_t w,
                                           input logic pipe);
    logic [15:0] h;
    h = 16'h0000;
    h[xfp_pkg::F_DATA +: 10] = w.data;
    h[xfp_pkg::F_SYNC]       = w.sync;
    h[xfp_pkg::F_PATTERN]    = w.pattern;
    if (pipe) begin
      // PIPE modes carry status in place of rate-match flags
      h[xfp_pkg::F_DELETE] = w.pipeStatus[0];
      h[xfp_pkg::F_INSERT] = w.pipeStatus[1];
    end else begin
      h[xfp_pkg::F_DELETE] = w.rmDelete;
      h[xfp_pkg::F_INSERT] = w.rmInsert;
    end
    h[xfp_pkg::F_DISP]       = w.runDisp;
    return h;
  endfunction : packHalf

  // ==========================================================
  // Rate divider and core clock selection
  // ==========================================================
  // Divider phase toggles on each recovered tick
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      divPhase_ff <= '0;
    end else begin
      divPhase_ff <= divPhase_ff ^ rxClkTick;
    end
  end

  // Per-channel source selection, fixed by parameters
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_clk
      // Divided recovered tick; transmit ticks never pass through here
      assign rxEffTick[gi] = rxClkTick[gi] & (~rxDiv2_ff[gi] | divPhase_ff[gi]);

      // Transmit FIFO write clock
      always_comb begin
        if (TX_FABRIC) begin
          nxt_writeTick[gi] = fabricTxTick[gi];
        end else if (TX_SRC == xfp_pkg::TX_SHARED) begin
          nxt_writeTick[gi] = txClkTick[0];
        end else begin
          nxt_writeTick[gi] = txClkTick[gi];
        end
      end

      // Receive FIFO read clock
      always_comb begin
        if (RX_FABRIC) begin
          nxt_readTick[gi] = fabricRxTick[gi];
        end else begin
          case (RX_SRC)
            xfp_pkg::RX_SHARED_TX: nxt_readTick[gi] = txClkTick[0];
            xfp_pkg::RX_OWN_TX:    nxt_readTick[gi] = txClkTick[gi];
            xfp_pkg::RX_OWN_RX:    nxt_readTick[gi] = rxEffTick[gi];
            default:               nxt_readTick[gi] = rxEffTick[gi];
          endcase
        end
      end
    end
  endgenerate

  // Registered strobes; build-time choice means no glitch on change
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txWriteTick <= '0;
      rxReadTick  <= '0;
    end else begin
      txWriteTick <= nxt_writeTick;
      rxReadTick  <= nxt_readTick;
    end
  end

  // ==========================================================
  // Receive bus
  // ==========================================================
  // Bus loads on the read strobe of its channel
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxBus       <= '0;
      rxBusValid  <= '0;
      syncPrev_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        rxBusValid[c] <= nxt_readTick[c] & rxWordValid[c];
        if (nxt_readTick[c] && rxWordValid[c]) begin
          rxBus[c][15:0]  <= packHalf(rxLower[c], pipeMode[c]);
          rxBus[c][31:16] <= packHalf(rxUpper[c], pipeMode[c]);
          syncPrev_ff[c]  <= rxLower[c].sync & rxUpper[c].sync;
        end
      end
    end
  end

  // ==========================================================
  // Reconfiguration sequencer
  // ==========================================================
  // Walks the address range while busy, then reports completion
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff    <= ST_IDLE;
      addrOut     <= 6'h00;
      addrValid   <= 1'b0;
      busy        <= 1'b0;
      channelDone <= 1'b0;
      mode_ff     <= 3'h0;
      chanMask_ff <= '0;
    end else if (reconfigReset) begin
      // Controller reset abandons any sequence
      state_ff    <= ST_IDLE;
      addrOut     <= 6'h00;
      addrValid   <= 1'b0;
      busy        <= 1'b0;
      channelDone <= 1'b0;
    end else begin
      channelDone <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (reconfigStart) begin
            // Latch mode and target channels
            state_ff  <= ST_RUN;
            mode_ff   <= reconfigModeSel;
            chanMask_ff <= writeAll ? '1 :
                           (NCH)'(1) << logicalChannel;
            addrOut   <= 6'h00;
            addrValid <= 1'b1;
            busy      <= 1'b1;
          end
        end
        ST_RUN: begin
          if (addrRestart) begin
            addrOut <= 6'h00;
          end else if (addrOut == ADDR_LAST) begin
            state_ff  <= ST_DONE;
            addrValid <= 1'b0;
          end else begin
            addrOut <= addrOut + 6'h01;
          end
        end
        ST_DONE: begin
          // One-cycle completion pulse
          state_ff    <= ST_IDLE;
          busy        <= 1'b0;
          channelDone <= 1'b1;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupts
  // ==========================================================
  // Events from the sequencer and the receive bus
  always_comb begin
    evt = 4'h0;
    evt[xfp_pkg::IRQ_DONE] = (state_ff == ST_DONE) & ~reconfigReset;
    for (int c = 0; c < NCH; c++) begin
      if (nxt_readTick[c] && rxWordValid[c]) begin
        if (!pipeMode[c]) begin
          evt[xfp_pkg::IRQ_DELETE] |= rxLower[c].rmDelete | rxUpper[c].rmDelete;
          evt[xfp_pkg::IRQ_INSERT] |= rxLower[c].rmInsert | rxUpper[c].rmInsert;
        end
        evt[xfp_pkg::IRQ_UNLOCK] |= syncPrev_ff[c] &
                                    ~(rxLower[c].sync & rxUpper[c].sync);
      end
    end
  end

  // Clear pattern from a write to the clear register
  assign clrMask = (doWrite && awAddr_ff == xfp_pkg::ADDR_IRQ_CLR && wStrb_ff[0]) ?
                   wData_ff[3:0] : 4'h0;

  // Sticky status; a new event wins over a clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqStat_ff <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irqStat_ff <= (irqStat_ff & ~clrMask) | evt;
      irq        <= |(((irqStat_ff & ~clrMask) | evt) & irqEn_ff);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  assign doWrite = awHeld_ff & wHeld_ff & ~bvalid;

  // Address and data taken in either order, answered after both
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= xfp_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
        wready   <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        case (awAddr_ff)
          xfp_pkg::ADDR_CTRL, xfp_pkg::ADDR_IRQ_CLR,
          xfp_pkg::ADDR_IRQ_EN: bresp <= xfp_pkg::RESP_OKAY;
          default:              bresp <= xfp_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        // Response accepted, reopen both channels
        bvalid    <= 1'b0;
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxDiv2_ff <= xfp_pkg::CTRL_RST[NCH-1:0];
      irqEn_ff  <= xfp_pkg::IRQ_EN_RST;
    end else if (doWrite && wStrb_ff[0]) begin
      if (awAddr_ff == xfp_pkg::ADDR_CTRL) begin
        rxDiv2_ff <= wData_ff[NCH-1:0];
      end
      if (awAddr_ff == xfp_pkg::ADDR_IRQ_EN) begin
        irqEn_ff <= wData_ff[3:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  // Read mux; unmapped addresses answer zero with an error
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    rdHit     = 1'b1;
    case (araddr)
      xfp_pkg::ADDR_CTRL: nxt_rdata[NCH-1:0] = rxDiv2_ff;
      xfp_pkg::ADDR_STATUS: begin
        nxt_rdata[xfp_pkg::S_BUSY]       = busy;
        nxt_rdata[xfp_pkg::S_AVAL]       = addrValid;
        nxt_rdata[xfp_pkg::S_ADDR +: 6]  = addrOut;
        nxt_rdata[xfp_pkg::S_MODE +: 3]  = mode_ff;
        nxt_rdata[xfp_pkg::S_MASK +: NCH] = chanMask_ff;
      end
      xfp_pkg::ADDR_IRQ_STAT: nxt_rdata[3:0] = irqStat_ff;
      xfp_pkg::ADDR_IRQ_CLR:  nxt_rdata = 32'h0000_0000;
      xfp_pkg::ADDR_IRQ_EN:   nxt_rdata[3:0] = irqEn_ff;
      default:                rdHit = 1'b0;
    endcase
  end

  // One read at a time, answered the cycle after the address
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= xfp_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= nxt_rdata;
        rresp   <= rdHit ? xfp_pkg::RESP_OKAY : xfp_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : xfp_fabric_port

// ==== bench/xfp_fabric_port_assertions.sv ====
// Checks on receive bus, clock strobes, reconfig status.
// Assumes the default shared transmit clocking and channel 0 traffic.
`timescale 1ns/10ps

module xfp_fabric_port_assertions #(
  parameter int NCH = 4  // Channels
) (
  // Clock and reset
  input wire logic                          mclk,
  input wire logic                          reset,
  // Channel side
  input wire xfp_pkg::xfp_word_t [NCH-1:0] rxLower,
  input wire xfp_pkg::xfp_word_t [NCH-1:0] rxUpper,
  input wire logic [NCH-1:0]                rxWordValid,
  input wire logic [NCH-1:0]                pipeMode,
  input wire logic [NCH-1:0]                txClkTick,
  input wire logic [NCH-1:0]                rxClkTick,
  // Fabric side
  input wire logic [NCH-1:0][31:0]          rxBus,
  input wire logic [NCH-1:0]                rxBusValid,
  input wire logic [NCH-1:0]                txWriteTick,
  // Reconfiguration status
  input wire logic                          busy,
  input wire logic                          addrValid,
  input wire logic [5:0]                    addrOut,
  input wire logic                          channelDone
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Receive bus layout
  // ==========================================================
  property p_data;
    rxBusValid[0] |-> rxBus[0][9:0] == $past(rxLower[0].data)
      && rxBus[0][25:16] == $past(rxUpper[0].data);
  endproperty
  a_data: assert property (p_data) else $error("data bits misplaced");
  property p_sync;
    rxBusValid[0] |-> {rxBus[0][26], rxBus[0][10]} == {$past(rxUpper[0].sync), $past(rxLower[0].sync)};
  endproperty
  a_sync: assert property (p_sync) else $error("lock bits misplaced");
  property p_pat;
    rxBusValid[0] |-> {rxBus[0][28], rxBus[0][12]} == $past({rxUpper[0].pattern, rxLower[0].pattern});
  endproperty
  a_pat: assert property (p_pat) else $error("pattern bits misplaced");
  property p_del;
    rxBusValid[0] && !$past(pipeMode[0]) |->
      {rxBus[0][29], rxBus[0][13]} == $past({rxUpper[0].rmDelete, rxLower[0].rmDelete});
  endproperty
  a_del: assert property (p_del) else $error("deletion bits misplaced");
  property p_ins;
    rxBusValid[0] && !$past(pipeMode[0]) |->
      {rxBus[0][30], rxBus[0][14]} == $past({rxUpper[0].rmInsert, rxLower[0].rmInsert});
  endproperty
  a_ins: assert property (p_ins) else $error("insertion bits misplaced");
  property p_disp;
    rxBusValid[0] |-> {rxBus[0][31], rxBus[0][15]} == $past({rxUpper[0].runDisp, rxLower[0].runDisp});
  endproperty
  a_disp: assert property (p_disp) else $error("disparity bits misplaced");

  // ==========================================================
  // FIFO clock strobes
  // ==========================================================
  property p_txShared;
    txWriteTick == {NCH{$past(txClkTick[0])}};
  endproperty
  a_txShared: assert property (p_txShared) else $error("tx write strobe wrong");
  property p_rxOwn;
    rxBusValid[0] |-> $past(rxClkTick[0] && rxWordValid[0]);
  endproperty
  a_rxOwn: assert property (p_rxOwn) else $error("rx read without own tick");

  // ==========================================================
  // Reconfiguration status
  // ==========================================================
  property p_start;
    $rose(busy) |-> addrValid && addrOut == 6'h00;
  endproperty
  a_start: assert property (p_start) else $error("start status wrong");
  property p_done;
    channelDone |-> !busy && !addrValid ##1 !channelDone;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
endmodule : xfp_fabric_port_assertions

bind xfp_fabric_port xfp_fabric_port_assertions #(.NCH(NCH)) xfp_fabric_port_assertions_i (
  .mclk, .reset, .rxLower, .rxUpper, .rxWordValid, .pipeMode, .txClkTick, .rxClkTick,
  .rxBus, .rxBusValid, .txWriteTick, .busy, .addrValid, .addrOut, .channelDone);

// ==== bench/xfp_fabric_model.sv ====
// Channel model: words with their parallel clock ticks.
// Assumes calls start just after a rising edge of mclk.
`timescale 1ns/10ps

module xfp_fabric_model #(
  parameter int NCH = 4  // Channels
) (
  // Clock
  input wire logic                     mclk,
  // Channel words and ticks
  output xfp_pkg::xfp_word_t [NCH-1:0] rxLower,
  output xfp_pkg::xfp_word_t [NCH-1:0] rxUpper,
  output logic [NCH-1:0]               rxWordValid,
  output logic [NCH-1:0]               pipeMode,
  output logic [NCH-1:0]               txClkTick,
  output logic [NCH-1:0]               rxClkTick
);
  // Idle lines at time zero
  initial begin
    rxLower = '0;
    rxUpper = '0;
    {rxWordValid, pipeMode, txClkTick, rxClkTick} = '0;
  end

  // One word per tick, every other cycle
  task automatic sendWords(input int ch, input xfp_pkg::xfp_word_t lo,
                           input xfp_pkg::xfp_word_t up, input logic pipe, input int n);
    for (int i = 0; i < n; i++) begin
      rxLower[ch] <= lo;
      rxUpper[ch] <= up;
      pipeMode[ch] <= pipe;
      rxWordValid[ch] <= 1'b1;
      rxClkTick[ch] <= 1'b1;  // Looped parallel clocks only
      txClkTick[ch] <= 1'b1;
      @(posedge mclk);
      rxLower[ch] <= xfp_pkg::xfp_word_t'(~lo);
      rxUpper[ch] <= xfp_pkg::xfp_word_t'(~up);
      {rxWordValid[ch], rxClkTick[ch], txClkTick[ch]} <= 3'h0;
      @(posedge mclk);
    end
  endtask : sendWords
endmodule : xfp_fabric_model

// ==== bench/test_xfp_fabric_port.sv ====
// Bench: register, receive bus, divider and reconfig tests.
// Assumes a fixed clock choice at build time: shared tx, own recovered rx.
`timescale 1ns/10ps

module test_xfp_fabric_port;
  localparam int         NCH   = 2;
  localparam logic [5:0] ALAST = 6'h03;  // Short reconfig sequence
  // AXI and control signals
  logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, irq, reconfigStart, writeAll, addrValid;
  logic busy, channelDone;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] reconfigModeSel;
  logic [0:0] logicalChannel;
  logic [5:0] addrOut;
  // Channel side
  xfp_pkg::xfp_word_t [NCH-1:0] rxLower, rxUpper;
  xfp_pkg::xfp_word_t lo, up;
  logic [NCH-1:0] rxWordValid, pipeMode, txClkTick, rxClkTick, rxBusValid, txWriteTick, rxReadTick;
  logic [NCH-1:0][31:0] rxBus;
  int num_errors, tests_run, rxCnt, txCnt, n;

  // Clock choices fixed by parameters
  xfp_fabric_port #(.NCH(NCH), .CHW(1), .ADDR_LAST(ALAST)) xfp_fabric_port_i (
    .mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rxLower, .rxUpper, .rxWordValid, .pipeMode, .txClkTick, .rxClkTick,
    .fabricTxTick('0), .fabricRxTick('0), .rxBus, .rxBusValid, .txWriteTick, .rxReadTick,
    .reconfigStart, .logicalChannel, .addrRestart(1'b0), .reconfigReset(1'b0),
    .reconfigModeSel, .writeAll, .addrValid, .addrOut, .channelDone, .busy, .irq);
  xfp_fabric_model #(.NCH(NCH)) xfp_fabric_model_i (
    .mclk, .rxLower, .rxUpper, .rxWordValid, .pipeMode, .txClkTick, .rxClkTick);

  // ==========================================================
  // Clock, pulse counters, watchdog
  // ==========================================================
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rxCnt += int'(rxBusValid[0]) + int'(rxReadTick[0]);
    txCnt += int'(txWriteTick[1]);
  end
  initial begin
    #100us;
    num_errors++;
    summarize();
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int k = 0;
    awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    num_errors += int'(k == 50);
    resp = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    num_errors += int'(k == 50);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axiRead
  // Expected bus half
  function automatic logic [15:0] half(input xfp_pkg::xfp_word_t w, input logic pipe);
    return {w.runDisp, pipe ? w.pipeStatus : {w.rmInsert, w.rmDelete}, w.pattern, 1'b0, w.sync, w.data};
  endfunction : half
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    reset = 1'b1; {awvalid, wvalid, bready, arvalid, rready, reconfigStart, writeAll} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; reconfigModeSel = '0; logicalChannel = '0;
    lo = '{10'h2A5, 1'b1, 1'b0, 1'b1, 1'b0, 2'h2, 1'b1};
    up = '{10'h15A, 1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0};
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    axiRead(xfp_pkg::ADDR_CTRL, d, r); check("ctrl reset", xfp_pkg::CTRL_RST, d);
    axiRead(xfp_pkg::ADDR_IRQ_EN, d, r); check("irq_en reset", 32'h0000_0000, d);
    axiRead(8'h14, d, r); check("unmapped read", {30'h0, xfp_pkg::RESP_SLVERR}, {30'h0, r});
    axiWrite(xfp_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r); check("status write", 32'h2, {30'h0, r});
    $display("Register test done");
    xfp_fabric_model_i.sendWords(0, lo, up, 1'b0, 1);
    check("bus plain", {half(up, 1'b0), half(lo, 1'b0)}, rxBus[0]);
    xfp_fabric_model_i.sendWords(0, lo, up, 1'b1, 1);
    check("bus pipe", {half(up, 1'b1), half(lo, 1'b1)}, rxBus[0]);
    axiRead(xfp_pkg::ADDR_IRQ_STAT, d, r); check("irq stat", 32'h6, d);
    axiWrite(xfp_pkg::ADDR_IRQ_EN, 32'h2, r); check("irq high", 32'h1, {31'h0, irq});
    axiWrite(xfp_pkg::ADDR_IRQ_CLR, 32'h2, r); check("irq low", 32'h0, {31'h0, irq});
    axiRead(xfp_pkg::ADDR_IRQ_STAT, d, r); check("irq cleared", 32'h4, d);
    $display("Receive bus test done");
    axiWrite(xfp_pkg::ADDR_CTRL, 32'h1, r);
    rxCnt = 0;
    txCnt = 0;
    xfp_fabric_model_i.sendWords(0, lo, up, 1'b0, 4);
    @(negedge mclk);
    check("divided reads", 32'd4, rxCnt);
    check("tx writes", 32'd4, txCnt);
    @(posedge mclk);
    $display("Divider test done");
    writeAll <= 1'b1; logicalChannel <= 1'b1; reconfigModeSel <= 3'h5;
    reconfigStart <= 1'b1;
    @(posedge mclk);
    reconfigStart <= 1'b0;
    n = 1;
    #1;
    while (!channelDone && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("reconfig edges", 32'(ALAST) + 32'd3, n);
    $display("Reconfig test done");
    summarize();
  end
endmodule : test_xfp_fabric_port
